// ==== rtl/rtc_timekeeping_core.v ====
// Contract
// - fifteen halving stages give one-hertz tick
// - divider_control field selects run, reset, backup
// - codes 01x or 100 start the divider
// - first update 500 ms after activation
// - low four bits pick periodic tap
// - first periodic flag after half period
// - data_format_select picks BCD or binary
// - control_reg_b bit 1 picks 12/24 hour
// - February has 29 days every fourth year
// - daylight saving applied when enabled
// - counters advance regardless of update inhibit
// - setting inhibit snapshots counters into shadow
// - inhibited writes reach only shadow copy
// - clearing inhibit loads shadow between updates
// - index/data pairs at 70h-73h, relocatable
// - 242 bytes RAM via pairs, bytes 0Eh/0Fh double as date/month alarm
// - alarm compare after each update sets flag
// - alarm bits 7:6 = 11 always match
// - update pending bit leads update 244 us while inhibit is clear
`timescale 1ns/1ps
`include "rtc_defines.vh"

module rtc_timekeeping_core #(
    parameter ADDR_W = 12
) (
    input  wire              I_REF_CLK,
    input  wire              I_RESET,
    input  wire              I_SLOW_CLOCK_IN,
    input  wire [ADDR_W-1:0] I_AWADDR,
    input  wire              I_AWVALID,
    output wire              O_AWREADY,
    input  wire [31:0]       I_WDATA,
    input  wire [3:0]        I_WSTRB,
    input  wire              I_WVALID,
    output wire              O_WREADY,
    output wire [1:0]        O_BRESP,
    output wire              O_BVALID,
    input  wire              I_BREADY,
    input  wire [ADDR_W-1:0] I_ARADDR,
    input  wire              I_ARVALID,
    output wire              O_ARREADY,
    output wire [31:0]       O_RDATA,
    output wire [1:0]        O_RRESP,
    output wire              O_RVALID,
    input  wire              I_RREADY,
    output wire              O_IRQ,
    output wire              O_BACKUP_OSC_EN
);

// ==========================================================
// helpers
function [7:0] to_bin;
    input [7:0] v;
    input       bcd;
    begin
        to_bin = bcd ? ({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]}) : v;
    end
endfunction

function [7:0] from_bin;
    input [7:0] b;
    input       bcd;
    reg   [7:0] q;
    reg   [7:0] r;
    begin
        q = b / 8'd10;
        r = b - q * 8'd10;
        from_bin = bcd ? {q[3:0], r[3:0]} : b;
    end
endfunction

function [7:0] hr_bin;
    input [7:0] h;
    input       bcd;
    input       m24;
    reg   [7:0] t;
    begin
        t = to_bin({1'b0, h[6:0]}, bcd);
        if (m24)
            hr_bin = to_bin(h, bcd);
        else
            hr_bin = ((t == 8'd12) ? 8'd0 : t) + (h[7] ? 8'd12 : 8'd0);
    end
endfunction

function [7:0] hr_pack;
    input [7:0] b;
    input       bcd;
    input       m24;
    reg   [7:0] t;
    reg   [7:0] f;
    begin
        t = (b >= 8'd12) ? b - 8'd12 : b;
        if (t == 8'd0)
            t = 8'd12;
        f = from_bin(t, bcd);
        hr_pack = m24 ? from_bin(b, bcd) : {(b >= 8'd12), f[6:0]};
    end
endfunction

function alm_match;
    input [7:0] a;
    input [7:0] t;
    begin
        alm_match = (a[7:6] == `UNCOND_MATCH) || (a == t);
    end
endfunction

// ==========================================================
// state
reg  [7:0]  ram [0:`RAM_BYTES-1];
reg  [55:0] tm_q;
reg  [55:0] sh_q;
reg  [23:0] alm_q;
reg  [7:0]  cra_q;
reg  [7:0]  crb_q;
reg  [7:0]  std_base_q;
reg  [7:0]  ext_base_q;
reg  [6:0]  std_idx_q;
reg  [6:0]  ext_idx_q;
reg  [14:0] div_q;
reg         run_q;
reg         sc_q;
reg         uip_q;
reg         upd_done_q;
reg         load_pend_q;
reg         dst_back_q;
reg         pf_q;
reg         af_q;
reg         uf_q;
reg         interrupt_request_flag_q;
reg         osc_en_q;
reg         awready_q;
reg         wready_q;
reg         bvalid_q;
reg  [1:0]  bresp_q;
reg         arready_q;
reg         rvalid_q;
reg  [1:0]  rresp_q;
reg  [31:0] rdata_q;
reg  [ADDR_W-1:0] awaddr_q;
reg  [7:0]  wdata_q;
reg         wlane_q;

wire        bcd     = ~crb_q[`CRB_DM];
wire        m24     = crb_q[`CRB_24H];
wire        set_b   = crb_q[`CRB_SET];
wire [2:0]  dv      = cra_q[`CRA_DIV_MSB:`CRA_DIV_LSB];
wire        normal  = (dv[2:1] == 2'b01) || (dv == 3'b100);
wire        sc_rise = I_SLOW_CLOCK_IN & ~sc_q;
wire [14:0] div_inc = div_q + 15'h0001;
wire        tick    = run_q & normal & sc_rise;
wire        upd     = tick & (div_q == 15'h7FFF);
wire [55:0] vis     = set_b ? sh_q : tm_q;

// ==========================================================
// periodic tap select
reg  [3:0]  tap_e;
reg  [14:0] tap_mask;
reg  [14:0] tap_half;
always @* begin
    tap_e    = (cra_q[3:0] < 4'h3) ? 4'h9 - cra_q[3:0] : cra_q[3:0] - 4'h1;
    tap_mask = (15'h0001 << tap_e) - 15'h0001;
    tap_half = 15'h0001 << (tap_e - 4'h1);
end
wire pf_hit = tick & (cra_q[3:0] != 4'h0) & ((div_inc & tap_mask) == tap_half);

// ==========================================================
// next second of the calendar
reg  [7:0]  s, m, h, dw, d, mo, y, dim;
reg         dst_fire;
reg  [55:0] nx;
always @* begin
    s  = to_bin(tm_q[7:0], bcd) + 8'd1;
    m  = to_bin(tm_q[15:8], bcd);
    h  = hr_bin(tm_q[23:16], bcd, m24);
    dw = to_bin(tm_q[31:24], bcd);
    d  = to_bin(tm_q[39:32], bcd);
    mo = to_bin(tm_q[47:40], bcd);
    y  = to_bin(tm_q[55:48], bcd);
    dst_fire = 1'b0;
    if (mo == 8'd2)
        dim = (y[1:0] == 2'b00) ? 8'd29 : 8'd28;
    else if (mo == 8'd4 || mo == 8'd6 || mo == 8'd9 || mo == 8'd11)
        dim = 8'd30;
    else
        dim = 8'd31;
    if (s == 8'd60) begin
        s = 8'd0;
        m = m + 8'd1;
        if (m == 8'd60) begin
            m = 8'd0;
            h = h + 8'd1;
            if (crb_q[`CRB_DSE] && dw == 8'd1 && h == 8'd2) begin
                if (mo == 8'd4 && d <= 8'd7)
                    h = 8'd3;
                else if (mo == 8'd10 && d >= 8'd25 && !dst_back_q) begin
                    h = 8'd1;
                    dst_fire = 1'b1;
                end
            end
            if (h == 8'd24) begin
                h  = 8'd0;
                dw = (dw == 8'd7) ? 8'd1 : dw + 8'd1;
                d  = d + 8'd1;
                if (d > dim) begin
                    d  = 8'd1;
                    mo = mo + 8'd1;
                    if (mo == 8'd13) begin
                        mo = 8'd1;
                        y  = (y == 8'd99) ? 8'd0 : y + 8'd1;
                    end
                end
            end
        end
    end
    nx = {from_bin(y, bcd), from_bin(mo, bcd), from_bin(d, bcd), from_bin(dw, bcd),
          hr_pack(h, bcd, m24), from_bin(m, bcd), from_bin(s, bcd)};
end

// ==========================================================
// host port decode
wire [7:0] ar_port = I_ARADDR[9:2];
wire [7:0] aw_port = awaddr_q[9:2];
wire       ar_io   = I_ARADDR[11:10] == `AXI_IO_WIN_SEL;
wire       aw_io   = awaddr_q[11:10] == `AXI_IO_WIN_SEL;
wire       do_rd   = arready_q & I_ARVALID;
wire       do_wr   = ~awready_q & ~wready_q & ~bvalid_q;

reg  [7:0] sbyte;
reg  [7:0] rd_byte;
reg        rd_ok;
reg        rd_crc;
always @* begin
    case (std_idx_q)
        `IDX_SEC:      sbyte = vis[7:0];
        `IDX_SEC_ALM:  sbyte = alm_q[7:0];
        `IDX_MIN:      sbyte = vis[15:8];
        `IDX_MIN_ALM:  sbyte = alm_q[15:8];
        `IDX_HOUR:     sbyte = vis[23:16];
        `IDX_HOUR_ALM: sbyte = alm_q[23:16];
        `IDX_DOW:      sbyte = vis[31:24];
        `IDX_DATE:     sbyte = vis[39:32];
        `IDX_MONTH:    sbyte = vis[47:40];
        `IDX_YEAR:     sbyte = vis[55:48];
        `IDX_CRA:      sbyte = {uip_q, cra_q[6:0]};
        `IDX_CRB:      sbyte = crb_q;
        `IDX_CRC:      sbyte = {interrupt_request_flag_q, pf_q, af_q, uf_q, 4'h0};
        `IDX_CRD:      sbyte = `CRD_VALUE;
        default:       sbyte = ram[{1'b0, std_idx_q} - {1'b0, `IDX_RAM_FIRST}];
    endcase
    rd_ok   = 1'b1;
    rd_crc  = 1'b0;
    rd_byte = 8'hFF;
    if (ar_io) begin
        if (ar_port == std_base_q)
            rd_byte = {1'b0, std_idx_q};
        else if (ar_port == (std_base_q | 8'h01)) begin
            rd_byte = sbyte;
            rd_crc  = (std_idx_q == `IDX_CRC);
        end else if (ar_port == ext_base_q)
            rd_byte = {1'b0, ext_idx_q};
        else if (ar_port == (ext_base_q | 8'h01))
            rd_byte = ram[`RAM_STD_BYTES + {1'b0, ext_idx_q}];
    end else if (I_ARADDR == `AXI_STD_BASE)
        rd_byte = std_base_q;
    else if (I_ARADDR == `AXI_EXT_BASE)
        rd_byte = ext_base_q;
    else begin
        rd_ok   = 1'b0;
        rd_byte = 8'h00;
    end
end

wire wr_map   = aw_io | (awaddr_q == `AXI_STD_BASE) | (awaddr_q == `AXI_EXT_BASE);
wire wr_go    = do_wr & wlane_q & aw_io;
wire wr_sdata = wr_go & (aw_port == (std_base_q | 8'h01));
wire wr_edata = wr_go & (aw_port == (ext_base_q | 8'h01));
wire wr_time  = wr_sdata & ((std_idx_q <= `IDX_YEAR) & ~std_idx_q[0] |
                            (std_idx_q == `IDX_DATE) | (std_idx_q == `IDX_YEAR));
wire wr_crb   = wr_sdata & (std_idx_q == `IDX_CRB);
wire [2:0] tslot = (std_idx_q == `IDX_DATE)  ? 3'd4 : (std_idx_q == `IDX_MONTH) ? 3'd5 :
                   (std_idx_q == `IDX_YEAR)  ? 3'd6 : std_idx_q[3:1];
wire crc_clr  = do_rd & rd_crc;

// ==========================================================
// ram and alarm bytes
always @(posedge I_REF_CLK) begin
    if (wr_sdata && std_idx_q >= `IDX_RAM_FIRST)
        ram[{1'b0, std_idx_q} - {1'b0, `IDX_RAM_FIRST}] <= wdata_q;
    if (wr_edata)
        ram[`RAM_STD_BYTES + {1'b0, ext_idx_q}] <= wdata_q;
end

// ==========================================================
// timekeeping and host registers
always @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
        tm_q        <= `TIME_RST;
        sh_q        <= `TIME_RST;
        alm_q       <= 24'h000000;
        cra_q       <= `CRA_RST;
        crb_q       <= `CRB_RST;
        std_base_q  <= `STD_BASE_RST;
        ext_base_q  <= `EXT_BASE_RST;
        std_idx_q   <= 7'h00;
        ext_idx_q   <= 7'h00;
        div_q       <= 15'h0000;
        run_q       <= 1'b0;
        sc_q        <= 1'b0;
        uip_q       <= 1'b0;
        upd_done_q  <= 1'b0;
        load_pend_q <= 1'b0;
        dst_back_q  <= 1'b0;
        pf_q        <= 1'b0;
        af_q        <= 1'b0;
        uf_q        <= 1'b0;
        interrupt_request_flag_q      <= 1'b0;
        osc_en_q    <= 1'b0;
    end else begin
        sc_q     <= I_SLOW_CLOCK_IN;
        run_q    <= normal;
        osc_en_q <= (dv != 3'b000);
        if (!normal)
            div_q <= 15'h0000;
        else if (!run_q)
            div_q <= `DIV_HALF;
        else if (sc_rise)
            div_q <= div_inc;
        uip_q      <= normal & ~set_b & (div_q >= 15'h7FFF - `UIP_LEAD_TICKS + 15'h0001);
        upd_done_q <= upd;
        if (upd) begin
            tm_q <= nx;
            if (dst_fire)
                dst_back_q <= 1'b1;
            else if (nx[47:40] != from_bin(8'd10, bcd))
                dst_back_q <= 1'b0;
        end else if (load_pend_q && !uip_q) begin
            tm_q        <= sh_q;
            load_pend_q <= 1'b0;
        end
        if (wr_time) begin
            if (set_b)
                sh_q[8*tslot +: 8] <= wdata_q;
            else
                tm_q[8*tslot +: 8] <= wdata_q;
        end
        if (wr_sdata && std_idx_q[0] && std_idx_q <= `IDX_HOUR_ALM)
            alm_q[8*std_idx_q[2:1] +: 8] <= wdata_q;
        if (wr_sdata && std_idx_q == `IDX_CRA)
            cra_q <= {1'b0, wdata_q[6:0]};
        if (wr_crb) begin
            crb_q <= wdata_q;
            if (wdata_q[`CRB_SET] && !set_b)
                sh_q <= tm_q;
            if (!wdata_q[`CRB_SET] && set_b)
                load_pend_q <= 1'b1;
        end
        if (wr_go && aw_port == std_base_q)
            std_idx_q <= wdata_q[6:0];
        if (wr_go && aw_port == ext_base_q)
            ext_idx_q <= wdata_q[6:0];
        if (do_wr && wlane_q && awaddr_q == `AXI_STD_BASE)
            std_base_q <= {wdata_q[7:1], 1'b0};
        if (do_wr && wlane_q && awaddr_q == `AXI_EXT_BASE)
            ext_base_q <= {wdata_q[7:1], 1'b0};
        pf_q <= pf_hit | (pf_q & ~crc_clr);
        uf_q <= upd_done_q | (uf_q & ~crc_clr);
        af_q <= (upd_done_q & alm_match(alm_q[7:0], tm_q[7:0])
                 & alm_match(alm_q[15:8], tm_q[15:8])
                 & alm_match(alm_q[23:16], tm_q[23:16])
                 & alm_match(ram[`RAM_DATE_ALM], tm_q[39:32])
                 & alm_match(ram[`RAM_MONTH_ALM], tm_q[47:40]))
                | (af_q & ~crc_clr);
        interrupt_request_flag_q <= (pf_q & crb_q[`CRB_PIE]) | (af_q & crb_q[`CRB_AIE])
                | (uf_q & crb_q[`CRB_UIE]);
    end
end

// ==========================================================
// axi4-lite slave handshakes
always @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q  <= 1'b0;
        bresp_q   <= `RESP_OKAY;
        arready_q <= 1'b1;
        rvalid_q  <= 1'b0;
        rresp_q   <= `RESP_OKAY;
        rdata_q   <= 32'h00000000;
        awaddr_q  <= {ADDR_W{1'b0}};
        wdata_q   <= 8'h00;
        wlane_q   <= 1'b0;
    end else begin
        if (awready_q && I_AWVALID) begin
            awaddr_q  <= {I_AWADDR[ADDR_W-1:2], 2'b00};
            awready_q <= 1'b0;
        end
        if (wready_q && I_WVALID) begin
            wdata_q  <= I_WDATA[7:0];
            wlane_q  <= I_WSTRB[0];
            wready_q <= 1'b0;
        end
        if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_q && I_BREADY) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
        end
        if (do_rd) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000, rd_byte};
            rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid_q && I_RREADY) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end
end

assign O_AWREADY       = awready_q;
assign O_WREADY        = wready_q;
assign O_BVALID        = bvalid_q;
assign O_BRESP         = bresp_q;
assign O_ARREADY       = arready_q;
assign O_RVALID        = rvalid_q;
assign O_RDATA         = rdata_q;
assign O_RRESP         = rresp_q;
assign O_IRQ           = interrupt_request_flag_q;
assign O_BACKUP_OSC_EN = osc_en_q;

endmodule // rtc_timekeeping_core

// ==== rtl/rtc_defines.vh ====
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// ==========================================================
// axi register map (byte addresses)
`define AXI_STD_BASE     12'h000
`define AXI_EXT_BASE     12'h004
`define AXI_IO_WIN_SEL   2'b01
`define STD_BASE_RST     8'h70
`define EXT_BASE_RST     8'h72
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// ==========================================================
// standard bank indices
`define IDX_SEC          7'h00
`define IDX_SEC_ALM      7'h01
`define IDX_MIN          7'h02
`define IDX_MIN_ALM      7'h03
`define IDX_HOUR         7'h04
`define IDX_HOUR_ALM     7'h05
`define IDX_DOW          7'h06
`define IDX_DATE         7'h07
`define IDX_MONTH        7'h08
`define IDX_YEAR         7'h09
`define IDX_CRA          7'h0A
`define IDX_CRB          7'h0B
`define IDX_CRC          7'h0C
`define IDX_CRD          7'h0D
`define IDX_RAM_FIRST    7'h0E
`define RAM_STD_BYTES    8'h72
`define RAM_BYTES        242
`define RAM_DATE_ALM     8'h00
`define RAM_MONTH_ALM    8'h01

// ==========================================================
// control fields
`define CRA_DIV_MSB      6
`define CRA_DIV_LSB      4
`define CRB_SET          7
`define CRB_PIE          6
`define CRB_AIE          5
`define CRB_UIE          4
`define CRB_DM           2
`define CRB_24H          1
`define CRB_DSE          0
`define CRA_RST          8'h00
`define CRB_RST          8'h02
`define CRD_VALUE        8'h80
`define TIME_RST         56'h00010101000000
`define UNCOND_MATCH     2'b11

// ==========================================================
// slow clock timing
`define SLOW_CLK_HZ      32768
`define DIV_STAGES       15
`define DIV_HALF         15'h4000
`define UIP_LEAD_US      244
`define UIP_LEAD_TICKS   ((`UIP_LEAD_US * `SLOW_CLK_HZ + 999999) / 1000000)

`endif

// ==== testbench/slow_osc_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// timekeeping clock source
// runs free like a crystal, sped up to half the reference rate
module slow_osc_model (
    input  wire i_clk,
    output reg  o_slow
);
    initial o_slow = 1'b0;
    always @(posedge i_clk) begin
        o_slow <= ~o_slow;
    end
endmodule // slow_osc_model

// ==== testbench/rtc_core_chk.sv ====
`timescale 1ns/1ps
// ==========================================================
// bus and control checks at the core's ports
module rtc_core_chk (
    input wire        I_REF_CLK,
    input wire        I_RESET,
    input wire        I_AWVALID,
    input wire        O_AWREADY,
    input wire        I_WVALID,
    input wire        O_WREADY,
    input wire [1:0]  O_BRESP,
    input wire        O_BVALID,
    input wire        I_BREADY,
    input wire        I_ARVALID,
    input wire        O_ARREADY,
    input wire [31:0] O_RDATA,
    input wire        O_RVALID,
    input wire        I_RREADY,
    input wire        O_BACKUP_OSC_EN
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    sequence wr_taken;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    sequence b_wait;
        O_BVALID && !I_BREADY;
    endsequence
    a_write_answer: assert property (wr_taken |=> !O_AWREADY && !O_WREADY ##1 O_BVALID)
        else $error("write response not on time");
    a_b_hold: assert property (b_wait |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    a_ready_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write accepted during response");
    a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
        else $error("read response not on time");
    a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    a_rdata_byte: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_resp_code: assert property (O_BVALID |-> O_BRESP == 2'b00 || O_BRESP == 2'b10)
        else $error("bad write response code");
    a_backup_cause: assert property ($changed(O_BACKUP_OSC_EN) |->
        $past(O_BVALID) || $past(O_BVALID, 2))
        else $error("backup enable moved without a write");
endmodule // rtc_core_chk

bind rtc_timekeeping_core rtc_core_chk chk_u (
    .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_BACKUP_OSC_EN(O_BACKUP_OSC_EN)
);

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "rtc_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [11:0] awaddr = 12'h000;
    reg         awvalid = 1'b0;
    reg  [31:0] wdata = 32'h00000000;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg  [11:0] araddr = 12'h000;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    wire        slow, awready, wready, bvalid, arready, rvalid, irq, bkup;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     mismatches = 0;
    integer     n_compared = 0;
    integer     k, p;
    reg  [7:0]  d;
    reg  [1:0]  r;

    always #50 clk = ~clk;

    slow_osc_model osc_u (.i_clk(clk), .o_slow(slow));

    rtc_timekeeping_core dut_u (
        .I_REF_CLK(clk), .I_RESET(rst), .I_SLOW_CLOCK_IN(slow),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_IRQ(irq), .O_BACKUP_OSC_EN(bkup)
    );

    // ==========================================================
    // bus access
    task end_of_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task axw(input [11:0] a, input [7:0] v, output [1:0] resp);
        integer n;
        reg     aw, w;
        begin
            aw = 1'b0;
            w = 1'b0;
            n = 0;
            @(posedge clk);
            awaddr <= a;
            wdata <= {24'h000000, v};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            while (!(aw && w) && n < 100) begin
                @(posedge clk);
                n++;
                if (awready && !aw) begin
                    aw = 1'b1;
                    awvalid <= 1'b0;
                end
                if (wready && !w) begin
                    w = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            do begin @(posedge clk); n++; end while (!bvalid && n < 100);
            bready <= 1'b1;
            @(posedge clk);
            resp = bresp;
            bready <= 1'b0;
            if (n >= 100) begin mismatches++; end_of_test; end
        end
    endtask

    task axr(input [11:0] a, output [7:0] v, output [1:0] resp);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            do begin @(posedge clk); n++; end while (!arready && n < 100);
            arvalid <= 1'b0;
            do begin @(posedge clk); n++; end while (!rvalid && n < 100);
            rready <= 1'b1;
            @(posedge clk);
            v = rdata[7:0];
            resp = rresp;
            rready <= 1'b0;
            if (n >= 100) begin mismatches++; end_of_test; end
        end
    endtask

    // index then data through the standard pair at 70h/71h
    task regw(input [6:0] i, input [7:0] v);
        begin
            axw(12'h5C0, {1'b0, i}, r);
            axw(12'h5C4, v, r);
        end
    endtask

    task regr(input [6:0] i, output [7:0] v);
        begin
            axw(12'h5C0, {1'b0, i}, r);
            axr(12'h5C4, v, r);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(bkup, 1'b0)
        axr(12'h000, d, r);
        `CHK(d, `STD_BASE_RST)
        axr(12'h004, d, r);
        `CHK(d, `EXT_BASE_RST)
        axr(12'h008, d, r);
        `CHK({r, d}, {`RESP_SLVERR, 8'h00})
        axw(12'h008, 8'h11, r);
        `CHK(r, `RESP_SLVERR)
        regr(`IDX_CRB, d);
        `CHK(d, `CRB_RST)
        regr(`IDX_CRD, d);
        `CHK(d, `CRD_VALUE)
        regw(7'h20, 8'hA5);
        regr(7'h20, d);
        `CHK(d, 8'hA5)
        axw(12'h5C8, 8'h7F, r);
        axw(12'h5CC, 8'h5A, r);
        axr(12'h5CC, d, r);
        `CHK(d, 8'h5A)
        axw(12'h000, 8'h40, r);
        axr(12'h5C0, d, r);
        `CHK(d, 8'hFF)
        axw(12'h500, 8'h0D, r);
        axr(12'h504, d, r);
        `CHK(d, `CRD_VALUE)
        axw(12'h000, 8'h70, r);
        `CHK(r, `RESP_OKAY)
        // 12-hour format, then one second before midnight, Feb 28 of a leap year
        regw(`IDX_CRB, 8'h30);
        regw(`IDX_SEC, 8'h59);
        regw(`IDX_MIN, 8'h59);
        regw(`IDX_HOUR, 8'h91);
        regw(`IDX_DATE, 8'h28);
        regw(`IDX_MONTH, 8'h02);
        regw(`IDX_YEAR, 8'h04);
        regw(`IDX_MIN_ALM, 8'hC0);
        regw(`IDX_HOUR_ALM, 8'hC0);
        regw(7'h0E, 8'hC0);
        regw(7'h0F, 8'hC0);
        regw(`IDX_CRB, 8'h30);
        regw(`IDX_CRA, 8'h20);
        repeat (32700) @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(bkup, 1'b1)
        repeat (100) @(posedge clk);
        `CHK(irq, 1'b1)
        regr(`IDX_CRC, d);
        `CHK(d & 8'hB0, 8'hB0)
        regr(`IDX_CRC, d);
        `CHK(d & 8'h30, 8'h00)
        `CHK(irq, 1'b0)
        regr(`IDX_SEC, d);
        `CHK(d, 8'h00)
        regr(`IDX_HOUR, d);
        `CHK(d, 8'h12)
        regr(`IDX_DATE, d);
        `CHK(d, 8'h29)
        regr(`IDX_YEAR, d);
        `CHK(d, 8'h04)
        regw(`IDX_CRB, 8'hB0);
        regw(`IDX_SEC, 8'h30);
        regr(`IDX_SEC, d);
        `CHK(d, 8'h30)
        regr(`IDX_MIN, d);
        `CHK(d, 8'h00)
        regw(`IDX_CRB, 8'h30);
        repeat (40) @(posedge clk);
        regr(`IDX_SEC, d);
        `CHK(d, 8'h30)
        // every divider code with a fast periodic tap
        for (k = 0; k < 8; k++) begin
            regw(`IDX_CRA, 8'h00);
            regr(`IDX_CRC, d);
            regw(`IDX_CRA, {1'b0, k[2:0], 4'h3});
            repeat (60) @(posedge clk);
            regr(`IDX_CRC, d);
            `CHK(d[6], (k >= 2 && k <= 4))
            `CHK(bkup, (k != 0))
        end
        // every periodic tap: flag at half period, two reference cycles a tick
        for (k = 1; k < 16; k++) begin
            p = (k < 3) ? (512 >> k) : (1 << (k - 1));
            regw(`IDX_CRA, 8'h00);
            regr(`IDX_CRC, d);
            regw(`IDX_CRA, 8'h20 | k[7:0]);
            if (p > 64) begin
                repeat (p - 30) @(posedge clk);
                regr(`IDX_CRC, d);
                `CHK(d & 8'h40, 8'h00)
            end
            repeat (60) @(posedge clk);
            regr(`IDX_CRC, d);
            `CHK(d & 8'h40, 8'h40)
        end
        end_of_test;
    end
endmodule // testbench
